/* File: include/atc_pkg.sv */
// Constants, register layouts, states and helpers for the converter trigger and timing control.
// Assumes an 8-bit register port and a single peripheral clock domain.
package atc_pkg;
    localparam logic [19:0] ATC_ADDR_REF_CMP = 20'hF0010;
    localparam logic [19:0] ATC_ADDR_TRIG_MODE = 20'hFFF32;
    localparam logic [7:0] ATC_REG_RESET = 8'h00;
    localparam logic [7:0] ATC_TRIG_WMASK = 8'hE3;
    localparam logic [7:0] ATC_REF_WMASK = 8'hFD;

    localparam logic [1:0] ATC_TMD_SW = 2'h0;
    localparam logic [1:0] ATC_TMD_HW_NOWAIT = 2'h2;
    localparam logic [1:0] ATC_TMD_HW_WAIT = 2'h3;

    localparam logic [1:0] ATC_TRS_TIMER = 2'h0;
    localparam logic [1:0] ATC_TRS_EVENT = 2'h1;
    localparam logic [1:0] ATC_TRS_CAL = 2'h2;
    localparam logic [1:0] ATC_TRS_ITV = 2'h3;

    localparam logic [1:0] ATC_REFP_VDD = 2'h0;
    localparam logic [1:0] ATC_REFP_PIN = 2'h1;
    localparam logic [1:0] ATC_REFP_INT = 2'h2;

    // Counts in conversion clocks unless noted
    localparam logic [6:0] ATC_STAB_NORMAL = 7'h08;
    localparam logic [6:0] ATC_STAB_LOWV = 7'h02;
    localparam logic [6:0] ATC_CONV_V1 = 7'h13;
    localparam logic [6:0] ATC_SAMP_V1 = 7'h07;
    localparam logic [6:0] ATC_CONV_V2 = 7'h11;
    localparam logic [6:0] ATC_SAMP_V2 = 7'h05;
    localparam logic [6:0] ATC_RES8_SHORTEN = 7'h02;
    // Peripheral clocks
    localparam logic [6:0] ATC_START_HW_WAIT = 7'h01;
    localparam logic [2:0] ATC_TRIG_BLOCK = 3'h4;

    typedef struct packed {
        logic [1:0] trig_mode;
        logic one_shot;
        logic [2:0] rsv;
        logic [1:0] trig_src;
    } atc_trig_cfg_type;

    typedef struct packed {
        logic [1:0] pos_ref;
        logic neg_ref;
        logic rsv4;
        logic range_check;
        logic low_power_wake_conversion;
        logic rsv1;
        logic res8;
    } atc_ref_cfg_type;

    typedef enum logic [1:0] {ATC_ST_IDLE, ATC_ST_START, ATC_ST_STAB, ATC_ST_CONV} atc_state_type;

    function automatic logic [6:0] atc_divisor(input logic [2:0] code);
        case (code)
            3'h0: return 7'h40;
            3'h1: return 7'h20;
            3'h2: return 7'h10;
            3'h3: return 7'h08;
            3'h4: return 7'h06;
            3'h5: return 7'h05;
            3'h6: return 7'h04;
            default: return 7'h02;
        endcase
    endfunction
endpackage

/* File: hw/atc_clk_div.sv */
// Conversion clock enable generator: one pulse every divisor peripheral clocks.
// Assumes the divider code is only changed while conversion is stopped.
`timescale 1ns/1ps
module atc_clk_div
    import atc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [2:0] div_code,
    output logic fad_en
);
    logic [6:0] cnt_q, cnt_d, gap_q, gap_d, last;

    always_comb
    begin
        last = atc_divisor(div_code) - 7'h01;
        cnt_d = (restart || cnt_q >= last) ? 7'h00 : cnt_q + 7'h01;
        gap_d = (restart || fad_en) ? 7'h01 : gap_q + 7'h01;
    end

    // Restart realigns phase so the first conversion clock is a full period
    assign fad_en = !restart && (cnt_q >= last);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= 7'h00;
            gap_q <= 7'h01;
        end
        else
        begin
            cnt_q <= cnt_d;
            gap_q <= gap_d;
        end
    end

    property p_fad_period;
        @(posedge core_clk) disable iff (!rst_n)
        (fad_en && $stable(div_code)) |-> gap_q == atc_divisor(div_code);
    endproperty
    a_fad_period: assert property (p_fad_period) else $error("conversion clock period wrong");
endmodule

/* File: hw/atc_trig_filter.sv */
// Hardware trigger source select with re-trigger guard for calendar and interval sources while low-power wake conversion is clear.
// Assumes trigger sources are one-cycle pulses on the peripheral clock.
`timescale 1ns/1ps
module atc_trig_filter
    import atc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] src_sel,
    input wire logic low_power_wake,
    input wire logic [3:0] irq_vec,
    output logic trig
);
    logic [2:0] block_q, block_d;
    logic guarded;

    always_comb
    begin
        guarded = (src_sel == ATC_TRS_CAL || src_sel == ATC_TRS_ITV) && !low_power_wake;
        trig = irq_vec[src_sel] && !(guarded && block_q != 3'h0);
        if (trig && guarded)
            block_d = ATC_TRIG_BLOCK;
        else if (block_q != 3'h0)
            block_d = block_q - 3'h1;
        else
            block_d = 3'h0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            block_q <= 3'h0;
        else
            block_q <= block_d;
    end

    property p_guard;
        @(posedge core_clk) disable iff (!rst_n)
        (trig && guarded) |=> (!trig || !guarded) [*4];
    endproperty
    a_guard: assert property (p_guard) else $error("calendar or interval trigger accepted too soon");

    property p_source;
        @(posedge core_clk) disable iff (!rst_n)
        trig |-> irq_vec[src_sel];
    endproperty
    a_source: assert property (p_source) else $error("trigger from unselected source");
endmodule

/* File: hw/atc_ctrl.sv */
// Converter trigger, timing and reference control: mode registers, sequencer, trigger handling.
// Assumes an 8-bit register write port and conversion-control bits supplied as plain inputs.
`timescale 1ns/1ps
module atc_ctrl
    import atc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [19:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] clock_divider_sel,
    input wire logic [1:0] timing_mode_sel,
    input wire logic comparator_enable,
    input wire logic scan_mode,
    input wire logic run_flag_wr_en,
    input wire logic run_flag_wr_val,
    input wire logic channel_rewrite,
    input wire logic timer_channel1_irq,
    input wire logic event_link_trig,
    input wire logic clock_calendar_irq,
    input wire logic interval_timer_irq,
    output logic conversion_run_flag,
    output logic conversion_done_irq,
    output logic start_wait_active,
    output logic stab_wait_active,
    output logic sampling_active,
    output logic approx_active,
    output logic [1:0] scan_channel,
    output logic pos_ref_vdd,
    output logic pos_ref_pin,
    output logic pos_ref_internal,
    output logic resolution_8bit
);
    atc_trig_cfg_type trig_cfg_q, trig_cfg_d;
    atc_ref_cfg_type ref_cfg_q, ref_cfg_d;
    atc_state_type state_q, state_d;
    logic run_q, run_d, done_q, done_d;
    logic [6:0] cnt_q, cnt_d, seen_q, seen_d;
    logic [1:0] scan_q, scan_d;
    logic fad_en, div_restart, hw_trig;
    logic sw_mode, nowait_mode, wait_mode, sw_start, last_conv, conv_end;
    logic [6:0] stab_len, conv_len, samp_len, start_len, conv_pos;

    atc_clk_div u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(div_restart),
        .div_code(clock_divider_sel),
        .fad_en(fad_en)
    );

    atc_trig_filter u_trig (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .src_sel(trig_cfg_q.trig_src),
        .low_power_wake(ref_cfg_q.low_power_wake_conversion),
        .irq_vec({interval_timer_irq, clock_calendar_irq, event_link_trig, timer_channel1_irq}),
        .trig(hw_trig)
    );

    // Register port; reserved bits are masked to read zero, except rsv4 of the reference register, which stays writable
    always_comb
    begin
        trig_cfg_d = trig_cfg_q;
        ref_cfg_d = ref_cfg_q;
        if (reg_wr_en && reg_addr == ATC_ADDR_TRIG_MODE)
            trig_cfg_d = atc_trig_cfg_type'(reg_wdata & ATC_TRIG_WMASK);
        if (reg_wr_en && reg_addr == ATC_ADDR_REF_CMP)
            ref_cfg_d = atc_ref_cfg_type'(reg_wdata & ATC_REF_WMASK);
        if (reg_addr == ATC_ADDR_TRIG_MODE)
            reg_rdata = trig_cfg_q;
        else if (reg_addr == ATC_ADDR_REF_CMP)
            reg_rdata = ref_cfg_q;
        else
            reg_rdata = 8'h00;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            trig_cfg_q <= atc_trig_cfg_type'(ATC_REG_RESET);
            ref_cfg_q <= atc_ref_cfg_type'(ATC_REG_RESET);
        end
        else
        begin
            trig_cfg_q <= trig_cfg_d;
            ref_cfg_q <= ref_cfg_d;
        end
    end

    // Timing selection; code 01 of the trigger mode is handled as software mode
    always_comb
    begin
        sw_mode = !trig_cfg_q.trig_mode[1];
        nowait_mode = trig_cfg_q.trig_mode == ATC_TMD_HW_NOWAIT;
        wait_mode = trig_cfg_q.trig_mode == ATC_TMD_HW_WAIT;
        stab_len = timing_mode_sel[1] ? ATC_STAB_LOWV : ATC_STAB_NORMAL;
        conv_len = timing_mode_sel[0] ? ATC_CONV_V2 : ATC_CONV_V1;
        if (ref_cfg_q.res8)
            conv_len = conv_len - ATC_RES8_SHORTEN;
        samp_len = timing_mode_sel[0] ? ATC_SAMP_V2 : ATC_SAMP_V1;
        // Software and no-wait start time is one period short of the divisor
        start_len = wait_mode ? ATC_START_HW_WAIT : atc_divisor(clock_divider_sel) - 7'h01;
        last_conv = trig_cfg_q.one_shot && (!scan_mode || scan_q == 2'h3);
        conv_end = state_q == ATC_ST_CONV && fad_en && cnt_q == 7'h00;
        sw_start = comparator_enable && sw_mode
            && ((run_flag_wr_en && run_flag_wr_val) || (channel_rewrite && run_q));
        conv_pos = conv_len - 7'h01 - cnt_q;
    end

    always_comb
    begin
        state_d = state_q;
        run_d = run_q;
        cnt_d = cnt_q;
        scan_d = scan_q;
        done_d = 1'b0;
        div_restart = 1'b0;
        case (state_q)
            ATC_ST_IDLE:
            begin
                // Triggers outside idle are dropped; spacing is software's duty
                if (hw_trig && comparator_enable && (wait_mode || (nowait_mode && run_q)))
                begin
                    state_d = ATC_ST_START;
                    cnt_d = start_len - 7'h01;
                    scan_d = 2'h0;
                    run_d = 1'b1;
                end
            end
            ATC_ST_START:
            begin
                if (cnt_q == 7'h00)
                begin
                    div_restart = 1'b1;
                    if (wait_mode)
                    begin
                        state_d = ATC_ST_STAB;
                        cnt_d = stab_len - 7'h01;
                    end
                    else
                    begin
                        state_d = ATC_ST_CONV;
                        cnt_d = conv_len - 7'h01;
                    end
                end
                else
                    cnt_d = cnt_q - 7'h01;
            end
            ATC_ST_STAB:
            begin
                if (fad_en)
                begin
                    if (cnt_q == 7'h00)
                    begin
                        state_d = ATC_ST_CONV;
                        cnt_d = conv_len - 7'h01;
                    end
                    else
                        cnt_d = cnt_q - 7'h01;
                end
            end
            ATC_ST_CONV:
            begin
                if (conv_end)
                begin
                    done_d = 1'b1;
                    scan_d = scan_mode ? scan_q + 2'h1 : 2'h0;
                    if (last_conv)
                    begin
                        state_d = ATC_ST_IDLE;
                        // No-wait one-shot keeps the flag set for the next trigger
                        if (!nowait_mode)
                            run_d = 1'b0;
                    end
                    else
                        cnt_d = conv_len - 7'h01;
                end
                else if (fad_en)
                    cnt_d = cnt_q - 7'h01;
            end
            default:
            begin
                state_d = ATC_ST_IDLE;
            end
        endcase
        // Software set wins over the end-of-conversion clear
        if (sw_start)
        begin
            state_d = ATC_ST_START;
            cnt_d = start_len - 7'h01;
            scan_d = 2'h0;
            run_d = 1'b1;
        end
        else if (run_flag_wr_en && run_flag_wr_val && nowait_mode)
            run_d = 1'b1;
        if (run_flag_wr_en && !run_flag_wr_val)
        begin
            run_d = 1'b0;
            state_d = ATC_ST_IDLE;
        end
        // Each conversion of a sequential or scan run counts its own clocks
        seen_d = (state_d != state_q || conv_end) ? 7'h00 : seen_q + {6'h00, fad_en};
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q <= ATC_ST_IDLE;
            run_q <= 1'b0;
            cnt_q <= 7'h00;
            scan_q <= 2'h0;
            done_q <= 1'b0;
            seen_q <= 7'h00;
        end
        else
        begin
            state_q <= state_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
            scan_q <= scan_d;
            done_q <= done_d;
            seen_q <= seen_d;
        end
    end

    assign conversion_run_flag = run_q;
    assign conversion_done_irq = done_q;
    assign start_wait_active = state_q == ATC_ST_START;
    assign stab_wait_active = state_q == ATC_ST_STAB;
    assign sampling_active = state_q == ATC_ST_CONV && conv_pos < samp_len;
    assign approx_active = state_q == ATC_ST_CONV && conv_pos >= samp_len;
    assign scan_channel = scan_q;
    assign pos_ref_vdd = ref_cfg_q.pos_ref == ATC_REFP_VDD;
    assign pos_ref_pin = ref_cfg_q.pos_ref == ATC_REFP_PIN;
    assign pos_ref_internal = ref_cfg_q.pos_ref == ATC_REFP_INT;
    assign resolution_8bit = ref_cfg_q.res8;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_start_to_stab;
        state_q == ATC_ST_START ##1 state_q == ATC_ST_STAB;
    endsequence

    property p_wait_path;
        (wait_mode && state_q == ATC_ST_START && cnt_q == 7'h00 && !run_flag_wr_en) |-> s_start_to_stab;
    endproperty
    a_wait_path: assert property (p_wait_path) else $error("wait mode skipped settling");

    property p_stab_len;
        (state_q == ATC_ST_STAB && fad_en && cnt_q == 7'h00)
            |-> seen_q == (timing_mode_sel[1] ? 7'h01 : 7'h07);
    endproperty
    a_stab_len: assert property (p_stab_len) else $error("settling length wrong");

    property p_conv_len;
        conv_end |-> seen_q == (timing_mode_sel[0] ? 7'h10 : 7'h12) - (ref_cfg_q.res8 ? 7'h02 : 7'h00);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    property p_continue;
        (conv_end && !last_conv && !run_flag_wr_en && !sw_start) |=> state_q == ATC_ST_CONV;
    endproperty
    a_continue: assert property (p_continue) else $error("later conversion not direct");

    property p_start_entry;
        (state_q == ATC_ST_START && $past(state_q) != ATC_ST_START)
            |-> ($past(state_q) == ATC_ST_IDLE || $past(sw_start));
    endproperty
    a_start_entry: assert property (p_start_entry) else $error("start time inside a run");

    property p_done;
        conv_end |=> conversion_done_irq ##1 !conversion_done_irq;
    endproperty
    a_done: assert property (p_done) else $error("done pulse missing");

    property p_wait_trig;
        (state_q == ATC_ST_IDLE && hw_trig && wait_mode && comparator_enable && !run_flag_wr_en)
            |=> run_q && state_q == ATC_ST_START;
    endproperty
    a_wait_trig: assert property (p_wait_trig) else $error("wait trigger did not start");

    property p_oneshot;
        (conv_end && last_conv && !nowait_mode && !run_flag_wr_en && !sw_start)
            |=> !run_q && state_q == ATC_ST_IDLE;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");

    property p_reset;
        $past(!rst_n) |-> trig_cfg_q == 8'h00 && ref_cfg_q == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("registers not cleared by reset");
endmodule

/* File: test/atc_trig_src.sv */
// Model of the on-chip trigger sources feeding the converter control.
// Assumes the bench raises fire for exactly one clock, just after a rising edge.
`timescale 1ns/1ps
module atc_trig_src
    import atc_pkg::*;
(
    input wire logic fire,
    input wire logic [1:0] fire_sel,
    output logic timer_channel1_irq,
    output logic event_link_trig,
    output logic clock_calendar_irq,
    output logic interval_timer_irq
);
    // One line pulses at a time, so a wrong source can be shown refused
    assign timer_channel1_irq = fire && (fire_sel == ATC_TRS_TIMER);
    assign event_link_trig = fire && (fire_sel == ATC_TRS_EVENT);
    assign clock_calendar_irq = fire && (fire_sel == ATC_TRS_CAL);
    assign interval_timer_irq = fire && (fire_sel == ATC_TRS_ITV);
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the converter trigger and timing control.
// Assumes trigger source model beside it; inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
module tb_top
    import atc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [19:0] reg_addr = 20'h00000;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [2:0] clock_divider_sel = 3'h0;
    logic [1:0] timing_mode_sel = 2'h0;
    logic comparator_enable = 1'b0;
    logic scan_mode = 1'b0;
    logic run_flag_wr_en = 1'b0;
    logic run_flag_wr_val = 1'b0;
    logic channel_rewrite = 1'b0;
    logic fire = 1'b0;
    logic [1:0] fire_sel = 2'h0;
    logic tm_irq, ev_trig, cal_irq, itv_irq;
    logic conversion_run_flag, conversion_done_irq, start_wait_active, stab_wait_active;
    logic sampling_active, approx_active, pos_ref_vdd, pos_ref_pin, pos_ref_internal;
    logic [1:0] scan_channel;
    logic resolution_8bit;
    int n_errors = 0;
    int samples_checked = 0;

    always #12.5 core_clk = ~core_clk;

    atc_trig_src u_atc_trig_src (.fire(fire), .fire_sel(fire_sel), .timer_channel1_irq(tm_irq),
        .event_link_trig(ev_trig), .clock_calendar_irq(cal_irq), .interval_timer_irq(itv_irq));

    atc_ctrl u_atc_ctrl (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clock_divider_sel(clock_divider_sel),
        .timing_mode_sel(timing_mode_sel), .comparator_enable(comparator_enable), .scan_mode(scan_mode),
        .run_flag_wr_en(run_flag_wr_en), .run_flag_wr_val(run_flag_wr_val), .channel_rewrite(channel_rewrite),
        .timer_channel1_irq(tm_irq), .event_link_trig(ev_trig), .clock_calendar_irq(cal_irq),
        .interval_timer_irq(itv_irq), .conversion_run_flag(conversion_run_flag),
        .conversion_done_irq(conversion_done_irq), .start_wait_active(start_wait_active),
        .stab_wait_active(stab_wait_active), .sampling_active(sampling_active),
        .approx_active(approx_active), .scan_channel(scan_channel), .pos_ref_vdd(pos_ref_vdd),
        .pos_ref_pin(pos_ref_pin), .pos_ref_internal(pos_ref_internal), .resolution_8bit(resolution_8bit));

    task automatic stop_test();
        $display("errors %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic fail(input string msg);
        n_errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
            fail($sformatf("register %h, want %h", got, exp));
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
            fail($sformatf("flag %b, want %b", got, exp));
    endtask

    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp)
            fail($sformatf("cycle count %0d, want %0d", got, exp));
    endtask

    function automatic logic busy();
        return (start_wait_active | stab_wait_active | sampling_active | approx_active) === 1'b1;
    endfunction

    function automatic int divof(input int code);
        int t[8] = '{64, 32, 16, 8, 6, 5, 4, 2};
        return t[code];
    endfunction

    task automatic tick();
        @(posedge core_clk);
        #2;
    endtask

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        tick();
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        tick();
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [19:0] a, input logic [7:0] exp);
        tick();
        reg_addr = a;
        #1;
        chk_reg(reg_rdata, exp);
    endtask

    task automatic runw(input logic v);
        tick();
        run_flag_wr_en = 1'b1;
        run_flag_wr_val = v;
        tick();
        run_flag_wr_en = 1'b0;
    endtask

    task automatic pulse(input logic [1:0] s);
        tick();
        fire = 1'b1;
        fire_sel = s;
        tick();
        fire = 1'b0;
    endtask

    // Mode fields only move while stopped and disabled; reference settles before use
    task automatic cfg(input logic [7:0] trg, input logic [7:0] rf, input logic [2:0] dv,
                       input logic [1:0] tm, input logic sc);
        tick();
        comparator_enable = 1'b0;
        wr(ATC_ADDR_TRIG_MODE, trg);
        wr(ATC_ADDR_REF_CMP, rf);
        clock_divider_sel = dv;
        timing_mode_sel = tm;
        scan_mode = sc;
        repeat ((rf[7:6] == ATC_REFP_INT) ? 200 : 1) tick();
        comparator_enable = 1'b1;
        repeat (40) tick();
    endtask

    // Counts active cycles of each phase until nd completion pulses
    task automatic measure(input int nd, input logic sc, output int cs, output int cw, output int cp, output int ca);
        int seen;
        int k;
        seen = 0;
        cs = 0;
        cw = 0;
        cp = 0;
        ca = 0;
        for (k = 0; k < 20000 && seen < nd; k++)
        begin
            if (conversion_done_irq === 1'b1)
            begin
                seen++;
                chk_reg({6'h00, scan_channel}, 8'(sc ? seen % 4 : 0));
            end
            if (seen < nd)
            begin
                cs += (start_wait_active === 1'b1);
                cw += (stab_wait_active === 1'b1);
                cp += (sampling_active === 1'b1);
                ca += (approx_active === 1'b1);
                tick();
            end
        end
        if (seen < nd)
        begin
            fail("completion pulse missing");
            stop_test();
        end
    endtask

    task automatic run_case(input logic [1:0] tmd, input logic os, input logic sc, input logic [2:0] dv,
                            input logic [1:0] tm, input logic r8, input int nd);
        int d;
        int n;
        int s;
        int smp;
        int cs;
        int cw;
        int cp;
        int ca;
        d = divof(dv);
        smp = tm[0] ? 5 : 7;
        n = (tm[0] ? 17 : 19) - (r8 ? 2 : 0);
        s = tm[1] ? 2 : 8;
        cfg({tmd, os, 3'h0, ATC_TRS_TIMER}, {7'h00, r8}, dv, tm, sc);
        chk_bit(resolution_8bit, r8);
        if (tmd != ATC_TMD_HW_WAIT)
            runw(1'b1);
        if (tmd != ATC_TMD_SW)
            pulse(ATC_TRS_TIMER);
        measure(nd, sc, cs, cw, cp, ca);
        chk_cnt(cs, (tmd == ATC_TMD_HW_WAIT) ? 1 : d - 1);
        chk_cnt(cw, (tmd == ATC_TMD_HW_WAIT) ? s * d : 0);
        chk_cnt(cp, nd * smp * d);
        chk_cnt(ca, nd * (n - smp) * d);
        repeat (2) tick();
        chk_bit(conversion_run_flag, !os || tmd == ATC_TMD_HW_NOWAIT);
        runw(1'b0);
        chk_bit(busy(), 1'b0);
    endtask

    // Wrong source refused, then a retrigger two cycles after an accepted one
    task automatic guard(input logic [1:0] s, input logic wake, input logic exp);
        cfg({ATC_TMD_HW_WAIT, 1'b1, 3'h0, s}, {5'h00, wake, 2'h0}, 3'h0, 2'h0, 1'b0);
        pulse(s ^ 2'h1);
        chk_bit(busy(), 1'b0);
        tick();
        fire = 1'b1;
        fire_sel = s;
        tick();
        fire = 1'b0;
        run_flag_wr_en = 1'b1;
        run_flag_wr_val = 1'b0;
        chk_bit(busy(), 1'b1);
        tick();
        run_flag_wr_en = 1'b0;
        fire = 1'b1;
        tick();
        fire = 1'b0;
        chk_bit(busy(), exp);
        runw(1'b0);
    endtask

    initial
    begin
        repeat (4) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        rd(ATC_ADDR_TRIG_MODE, ATC_REG_RESET);
        rd(ATC_ADDR_REF_CMP, ATC_REG_RESET);
        chk_bit(pos_ref_vdd, 1'b1);
        wr(ATC_ADDR_TRIG_MODE, 8'hFF);
        wr(ATC_ADDR_REF_CMP, 8'hFF);
        wr(20'hF0011, 8'hFF);
        rd(ATC_ADDR_TRIG_MODE, 8'hE3);
        rd(ATC_ADDR_REF_CMP, 8'hFD);
        rd(20'hF0011, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            cfg(8'h00, 8'(c << 6), 3'h7, 2'h0, 1'b0);
            chk_bit(pos_ref_vdd, c == 0);
            chk_bit(pos_ref_pin, c == 1);
            chk_bit(pos_ref_internal, c == 2);
        end
        run_case(ATC_TMD_SW, 1'b1, 1'b0, 3'h7, 2'h0, 1'b0, 1);
        run_case(ATC_TMD_SW, 1'b1, 1'b0, 3'h0, 2'h1, 1'b0, 1);
        run_case(ATC_TMD_SW, 1'b1, 1'b0, 3'h1, 2'h2, 1'b1, 1);
        run_case(ATC_TMD_SW, 1'b1, 1'b0, 3'h2, 2'h3, 1'b0, 1);
        run_case(ATC_TMD_SW, 1'b1, 1'b0, 3'h3, 2'h0, 1'b1, 1);
        run_case(ATC_TMD_SW, 1'b0, 1'b0, 3'h4, 2'h1, 1'b1, 2);
        run_case(ATC_TMD_SW, 1'b1, 1'b1, 3'h5, 2'h2, 1'b0, 4);
        run_case(ATC_TMD_HW_WAIT, 1'b1, 1'b0, 3'h6, 2'h0, 1'b0, 1);
        run_case(ATC_TMD_HW_WAIT, 1'b0, 1'b0, 3'h5, 2'h3, 1'b1, 2);
        run_case(ATC_TMD_HW_WAIT, 1'b1, 1'b1, 3'h7, 2'h1, 1'b0, 4);
        run_case(ATC_TMD_HW_NOWAIT, 1'b1, 1'b0, 3'h3, 2'h2, 1'b0, 1);
        guard(ATC_TRS_CAL, 1'b0, 1'b0);
        guard(ATC_TRS_ITV, 1'b0, 1'b0);
        guard(ATC_TRS_TIMER, 1'b0, 1'b1);
        guard(ATC_TRS_EVENT, 1'b0, 1'b1);
        guard(ATC_TRS_CAL, 1'b1, 1'b1);
        guard(ATC_TRS_ITV, 1'b1, 1'b1);
        // Channel rewrite while running restarts with a fresh start time
        cfg(8'h00, 8'h00, 3'h7, 2'h0, 1'b0);
        runw(1'b1);
        repeat (8) tick();
        chk_bit(start_wait_active, 1'b0);
        channel_rewrite = 1'b1;
        tick();
        channel_rewrite = 1'b0;
        chk_bit(start_wait_active, 1'b1);
        runw(1'b0);
        cfg(8'h20, 8'h81, 3'h0, 2'h0, 1'b0);
        runw(1'b1);
        rst_n = 1'b0;
        repeat (4) tick();
        rst_n = 1'b1;
        chk_bit(busy() || conversion_run_flag === 1'b1, 1'b0);
        rd(ATC_ADDR_TRIG_MODE, ATC_REG_RESET);
        rd(ATC_ADDR_REF_CMP, ATC_REG_RESET);
        stop_test();
    end
endmodule
